// ===== pkg/ddrci_pkg.sv
`default_nettype none
package ddrci_pkg;

  // Command codes as {cs_n, ras_n, cas_n, we_n}.
  typedef enum logic [3:0] {
    DDRCI_CMD_MRS   = 4'h0,
    DDRCI_CMD_REF   = 4'h1,
    DDRCI_CMD_PRE   = 4'h2,
    DDRCI_CMD_ACT   = 4'h3,
    DDRCI_CMD_WR    = 4'h4,
    DDRCI_CMD_RD    = 4'h5,
    DDRCI_CMD_ZQ    = 4'h6,
    DDRCI_CMD_NOP   = 4'h7,
    DDRCI_CMD_DESEL = 4'h8
  } ddrci_cmd_t;

  typedef enum logic [1:0] {
    DDRCI_ST_ACTIVE = 2'h0,
    DDRCI_ST_PPD    = 2'h1,
    DDRCI_ST_APD    = 2'h2,
    DDRCI_ST_SREF   = 2'h3
  } ddrci_state_t;

  localparam int DDRCI_BANKS = 8;
  localparam int DDRCI_BANK_W = 3;
  localparam int DDRCI_DQ_W = 16;
  localparam int DDRCI_ODT_W = 20;

  // Width code: 0 narrow (x4/x8), 1 sixteen-bit.
  localparam logic DDRCI_WIDTH_NARROW = 1'b0;
  localparam logic DDRCI_WIDTH_X16 = 1'b1;

  // Termination mask bit positions: dq[15:0], lower strobe, upper strobe, lower mask, upper mask.
  localparam int DDRCI_ODT_LDQS = 16;
  localparam int DDRCI_ODT_UDQS = 17;
  localparam int DDRCI_ODT_LDM = 18;
  localparam int DDRCI_ODT_UDM = 19;
  localparam int DDRCI_NARROW_DQ = 8;

  localparam logic [DDRCI_BANKS-1:0] DDRCI_BANKS_IDLE_RST = 8'h00;

endpackage

`default_nettype wire

// ===== verilog/ddrci_sync.sv
`timescale 1ns/1ps
`default_nettype none

module ddrci_sync (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Level in and out
  input wire logic d_in,
  output logic q_out
);

  logic meta_reg;
  logic meta_next;
  logic q_reg;
  logic q_next;

  always_comb begin
    meta_next = d_in;
    q_next = meta_reg;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= 1'b0;
      q_reg <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      q_reg <= q_next;
    end
  end

  assign q_out = q_reg;

endmodule // ddrci_sync

`default_nettype wire

// ===== verilog/ddrci_ddr_out.sv
`timescale 1ns/1ps
`default_nettype none

// Double-rate read data: rise half during high clock phase, fall half in low phase.
module ddrci_ddr_out
  import ddrci_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Data
  input wire logic [DDRCI_DQ_W-1:0] rise_data,
  input wire logic [DDRCI_DQ_W-1:0] fall_data,
  input wire logic drive_en,
  output logic [DDRCI_DQ_W-1:0] dq_out,
  output logic dq_oe_n
);

  logic [DDRCI_DQ_W-1:0] rise_reg;
  logic [DDRCI_DQ_W-1:0] rise_next;
  logic [DDRCI_DQ_W-1:0] fall_reg;
  logic [DDRCI_DQ_W-1:0] fall_next;
  logic en_reg;
  logic en_next;

  always_comb begin
    rise_next = rise_data;
    fall_next = fall_data;
    en_next = drive_en;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rise_reg <= '0;
      fall_reg <= '0;
      en_reg <= 1'b0;
    end else begin
      rise_reg <= rise_next;
      fall_reg <= fall_next;
      en_reg <= en_next;
    end
  end

  // Clock used as a select so both crossings carry a beat.
  assign dq_out = mclk ? rise_reg : fall_reg; // [RULE2]
  assign dq_oe_n = ~en_reg;

endmodule // ddrci_ddr_out

`default_nettype wire

// ===== verilog/ddrci_ctrl.sv
// Functional notes
// RULE1: Capture all address and control inputs on the rising true-clock crossing.
// RULE2: Read data drives on both clock crossings, two beats per period.
// RULE3: Clock enable high keeps clocks, buffers and drivers on; low turns them off.
// RULE4: Clock enable low: idle banks give precharge power-down or self refresh, else active.
// RULE5: Clock enable sampled synchronously for power-down entry, exit and self refresh entry.
// RULE6: Self refresh exit comes from rising clock enable, without the clock. The code needs mclk running, since cke passes two mclk flops in ddrci_sync.
// RULE7: Controller keeps clock enable high throughout reads and writes.
// RULE8: Power-down disables all input buffers except clock pair, termination and enable.
// RULE9: Self refresh disables every input buffer except clock enable.
// RULE10: Commands with chip select high are ignored.
// RULE11: Chip select is part of the command code and picks the rank.
// RULE12: Registered termination enable high switches internal termination on.
// RULE13: Narrow widths terminate only data, strobe pairs, read strobe and mask.
// RULE14: Sixteen-bit width terminates data, both strobe pairs and both masks.
// RULE15: Termination disabled in extended mode register means termination input ignored.
// RULE16: Row, column strobes, write enable and chip select decode each command.
// RULE17: Clock enable is registered each rising edge and drives state changes.
`timescale 1ns/1ps
`default_nettype none

module ddrci_ctrl
  import ddrci_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Command pins (already on mclk)
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [DDRCI_BANK_W-1:0] bank_addr,
  input wire logic a10,
  input wire logic odt,
  // Configuration from mode registers
  input wire logic width_x16,
  input wire logic emr_odt_enable,
  // Read data from core
  input wire logic [DDRCI_DQ_W-1:0] rd_rise,
  input wire logic [DDRCI_DQ_W-1:0] rd_fall,
  input wire logic rd_valid,
  // Data pins
  output logic [DDRCI_DQ_W-1:0] dq_out,
  output logic dq_oe_n,
  // Decoded command
  output ddrci_cmd_t cmd,
  output logic cmd_valid,
  output logic [DDRCI_BANK_W-1:0] cmd_bank,
  // Power and buffer status
  output ddrci_state_t pwr_state,
  output logic int_clk_en,
  output logic cmd_buf_en,
  output logic clk_buf_en,
  output logic odt_buf_en,
  output logic out_drv_en,
  // Termination per pin
  output logic [DDRCI_ODT_W-1:0] odt_on
);

  ////////////////////////////////////////////////////////////////////////////
  // Synchronised clock enable path (two mclk flops) for self refresh exit.

  logic cke_async;

  ddrci_sync u_cke_sync (
    .mclk(mclk),
    .nrst(nrst),
    .d_in(cke),
    .q_out(cke_async)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Input capture.

  function automatic ddrci_cmd_t ddrci_decode(input logic c, input logic r, input logic ca, input logic w);
    if (c) begin
      ddrci_decode = DDRCI_CMD_DESEL; // [RULE10]
    end else begin
      ddrci_decode = ddrci_cmd_t'({1'b0, r, ca, w}); // [RULE11] [RULE16]
    end
  endfunction

  ddrci_state_t state_reg;
  ddrci_state_t state_next;
  logic cke_reg;
  logic cke_next;
  logic cs_n_reg;
  logic cs_n_next;
  logic ras_n_reg;
  logic ras_n_next;
  logic cas_n_reg;
  logic cas_n_next;
  logic we_n_reg;
  logic we_n_next;
  logic a10_reg;
  logic a10_next;
  logic odt_reg;
  logic odt_next;
  logic [DDRCI_BANK_W-1:0] bank_reg;
  logic [DDRCI_BANK_W-1:0] bank_next;
  logic [DDRCI_BANKS-1:0] open_reg;
  logic [DDRCI_BANKS-1:0] open_next;
  logic buf_on;
  logic clk_on;
  ddrci_cmd_t cur_cmd;

  always_comb begin
    buf_on = (state_reg == DDRCI_ST_ACTIVE);
    clk_on = (state_reg != DDRCI_ST_SREF);
    cke_next = cke; // [RULE17]
    // Frozen buffers hold the last sample, except chip select, which reads high, and termination, which reads low.
    cs_n_next = buf_on ? cs_n : 1'b1; // [RULE8] [RULE9]
    ras_n_next = buf_on ? ras_n : ras_n_reg;
    cas_n_next = buf_on ? cas_n : cas_n_reg;
    we_n_next = buf_on ? we_n : we_n_reg;
    a10_next = buf_on ? a10 : a10_reg;
    bank_next = buf_on ? bank_addr : bank_reg;
    odt_next = clk_on ? odt : 1'b0; // [RULE8] [RULE9]
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      // Reset to the pin's idle level, so the release itself is not read as a power-down request.
      cke_reg <= 1'b1;
      cs_n_reg <= 1'b1;
      ras_n_reg <= 1'b1;
      cas_n_reg <= 1'b1;
      we_n_reg <= 1'b1;
      a10_reg <= 1'b0;
      bank_reg <= '0;
      odt_reg <= 1'b0;
    end else begin
      cke_reg <= cke_next;
      cs_n_reg <= cs_n_next; // [RULE1]
      ras_n_reg <= ras_n_next;
      cas_n_reg <= cas_n_next;
      we_n_reg <= we_n_next;
      a10_reg <= a10_next;
      bank_reg <= bank_next;
      odt_reg <= odt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bank tracking.

  assign cur_cmd = ddrci_decode(cs_n_reg, ras_n_reg, cas_n_reg, we_n_reg);

  always_comb begin
    open_next = open_reg;
    // Low-power states decode nothing, so open rows are kept as they were.
    if (state_reg == DDRCI_ST_ACTIVE) begin
      case (cur_cmd)
        DDRCI_CMD_ACT: begin
          open_next[bank_reg] = 1'b1;
        end
        DDRCI_CMD_PRE: begin
          if (a10_reg) begin
            open_next = '0;
          end else begin
            open_next[bank_reg] = 1'b0;
          end
        end
        default: begin
          open_next = open_reg;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      open_reg <= DDRCI_BANKS_IDLE_RST;
    end else begin
      open_reg <= open_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power state.

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      DDRCI_ST_ACTIVE: begin
        if (!cke_reg) begin // [RULE5]
          if (open_reg != '0) begin
            state_next = DDRCI_ST_APD; // [RULE4]
          end else if (cur_cmd == DDRCI_CMD_REF) begin
            state_next = DDRCI_ST_SREF; // [RULE4]
          end else begin
            state_next = DDRCI_ST_PPD; // [RULE4]
          end
        end
      end
      DDRCI_ST_PPD, DDRCI_ST_APD: begin
        if (cke_reg) begin // [RULE5] [RULE17]
          state_next = DDRCI_ST_ACTIVE;
        end
      end
      DDRCI_ST_SREF: begin
        // The exit waits for cke through the two mclk flops of ddrci_sync, so the clock must run here; the synchronised level is the only trigger.
        if (cke_async) begin // [RULE6]
          state_next = DDRCI_ST_ACTIVE;
        end
      end
      default: begin
        state_next = DDRCI_ST_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= DDRCI_ST_ACTIVE;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs and termination.

  logic [DDRCI_ODT_W-1:0] odt_mask;

  always_comb begin
    odt_mask = '0;
    if (width_x16 == DDRCI_WIDTH_X16) begin
      odt_mask = '1; // [RULE14]
    end else begin
      odt_mask[DDRCI_NARROW_DQ-1:0] = '1; // [RULE13]
      odt_mask[DDRCI_ODT_LDQS] = 1'b1;
      odt_mask[DDRCI_ODT_LDM] = 1'b1;
    end
  end

  assign odt_on = (odt_reg && emr_odt_enable) ? odt_mask : '0; // [RULE12] [RULE15]
  assign cmd = cur_cmd;
  assign cmd_valid = buf_on && (cur_cmd != DDRCI_CMD_DESEL) && (cur_cmd != DDRCI_CMD_NOP);
  assign cmd_bank = bank_reg;
  assign pwr_state = state_reg;
  assign int_clk_en = buf_on; // [RULE3]
  assign cmd_buf_en = buf_on;
  assign clk_buf_en = clk_on;
  assign odt_buf_en = clk_on;
  assign out_drv_en = buf_on;

  ddrci_ddr_out u_ddr_out (
    .mclk(mclk),
    .nrst(nrst),
    .rise_data(rd_rise),
    .fall_data(rd_fall),
    .drive_en(rd_valid && buf_on), // [RULE3] [RULE7]
    .dq_out(dq_out),
    .dq_oe_n(dq_oe_n)
  );

endmodule // ddrci_ctrl

`default_nettype wire

// ===== bench/ddrci_ctrl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ddrci_ctrl_chk
  import ddrci_pkg::*;
(
  // Clock, reset and inputs
  input wire logic mclk,
  input wire logic nrst,
  input wire logic cke,
  input wire logic width_x16,
  input wire logic emr_odt_enable,
  // Observed outputs
  input wire ddrci_cmd_t cmd,
  input wire logic cmd_valid,
  input wire ddrci_state_t pwr_state,
  input wire logic int_clk_en,
  input wire logic cmd_buf_en,
  input wire logic clk_buf_en,
  input wire logic odt_buf_en,
  input wire logic out_drv_en,
  input wire logic [DDRCI_ODT_W-1:0] odt_on
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////
  sequence s_pd_wake;
    pwr_state inside {DDRCI_ST_PPD, DDRCI_ST_APD} && cke;
  endsequence
  sequence s_sref_wake;
    pwr_state == DDRCI_ST_SREF && cke;
  endsequence
  chk_active_on: assert property (
    pwr_state == DDRCI_ST_ACTIVE |-> int_clk_en && cmd_buf_en && out_drv_en) else $error("active enables low");
  chk_pd_bufs: assert property (
    pwr_state inside {DDRCI_ST_PPD, DDRCI_ST_APD} |-> clk_buf_en && odt_buf_en && !cmd_buf_en && !int_clk_en)
    else $error("power-down buffers wrong");
  chk_sref_ignore: assert property (
    pwr_state == DDRCI_ST_SREF && $past(pwr_state) == DDRCI_ST_SREF |-> odt_on == '0 && !clk_buf_en && !odt_buf_en)
    else $error("self refresh buffers wrong");
  chk_emr_off: assert property (
    !emr_odt_enable && !$past(emr_odt_enable) |-> odt_on == '0) else $error("termination not ignored");
  chk_odt_narrow: assert property (
    !width_x16 && !$past(width_x16) |-> odt_on[15:8] == 8'h00 && !odt_on[DDRCI_ODT_UDQS] && !odt_on[DDRCI_ODT_UDM])
    else $error("narrow termination scope");
  chk_odt_x16: assert property (
    width_x16 && $stable({width_x16, emr_odt_enable}) |-> odt_on == '0 || odt_on == '1)
    else $error("x16 termination scope");
  chk_desel_mask: assert property (
    cmd == DDRCI_CMD_DESEL |-> !cmd_valid) else $error("deselected command valid");
  chk_valid_code: assert property (
    cmd_valid |-> cmd != DDRCI_CMD_NOP) else $error("valid flag on no-op");
  chk_pd_exit: assert property (
    s_pd_wake |-> ##[1:2] pwr_state == DDRCI_ST_ACTIVE) else $error("power-down exit late");
  chk_sref_exit: assert property (
    s_sref_wake |-> ##[1:4] pwr_state == DDRCI_ST_ACTIVE) else $error("self refresh exit late");
  chk_cke_entry: assert property (
    pwr_state == DDRCI_ST_ACTIVE && !cke |-> ##[1:2] pwr_state != DDRCI_ST_ACTIVE) else $error("no low-power entry");
endmodule // ddrci_ctrl_chk
bind ddrci_ctrl ddrci_ctrl_chk u_chk (.mclk, .nrst, .cke, .width_x16, .emr_odt_enable, .cmd, .cmd_valid,
  .pwr_state, .int_clk_en, .cmd_buf_en, .clk_buf_en, .odt_buf_en, .out_drv_en, .odt_on);
`default_nettype wire

// ===== bench/ddrci_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module ddrci_host_model
  import ddrci_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Requests from the bench
  input wire ddrci_cmd_t req_cmd,
  input wire logic req_cke,
  input wire logic req_odt,
  // Pins toward the device
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic odt
);
  logic [2:0] last_reg;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      last_reg <= 3'h0;
    end else begin
      last_reg <= {ras_n, cas_n, we_n};
    end
  end
  // Deselected pins wander so a device that decodes them anyway is caught.
  always_comb begin
    cs_n = req_cmd[3];
    {ras_n, cas_n, we_n} = req_cmd[3] ? ~last_reg : req_cmd[2:0];
    cke = req_cke || req_cmd inside {DDRCI_CMD_RD, DDRCI_CMD_WR};
    odt = req_odt;
  end
endmodule // ddrci_host_model
`default_nettype wire

// ===== bench/ddrci_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ddrci_ctrl_tb;
  import ddrci_pkg::*;
  logic mclk, nrst, cke, cs_n, ras_n, cas_n, we_n, a10, odt, req_cke, req_odt, width_x16, emr_odt_enable;
  logic rd_valid, dq_oe_n, cmd_valid, int_clk_en, cmd_buf_en, clk_buf_en, odt_buf_en, out_drv_en;
  logic [2:0] bank_addr, cmd_bank;
  logic [15:0] rd_rise, rd_fall, dq_out;
  logic [19:0] odt_on;
  ddrci_cmd_t req_cmd, cmd;
  ddrci_state_t pwr_state;
  int mismatches, compares;
  ddrci_host_model u_host (.mclk, .nrst, .req_cmd, .req_cke, .req_odt, .cke, .cs_n, .ras_n, .cas_n, .we_n, .odt);
  ddrci_ctrl u_dut (.mclk, .nrst, .cke, .cs_n, .ras_n, .cas_n, .we_n, .bank_addr, .a10, .odt, .width_x16,
    .emr_odt_enable, .rd_rise, .rd_fall, .rd_valid, .dq_out, .dq_oe_n, .cmd, .cmd_valid, .cmd_bank, .pwr_state,
    .int_clk_en, .cmd_buf_en, .clk_buf_en, .odt_buf_en, .out_drv_en, .odt_on);
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////
  task automatic check(input string n, input logic [19:0] e, input logic [19:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic send(input ddrci_cmd_t c, input logic k, input logic o);
    @(negedge mclk);
    req_cmd = c;
    req_cke = k;
    req_odt = o;
  endtask
  task automatic t_cmds;
    for (int i = 0; i < 9; i++) begin
      bank_addr = 3'(i);
      send(ddrci_cmd_t'(i), 1'b1, 1'b0);
      send(DDRCI_CMD_NOP, 1'b1, 1'b0);
      check("cmd", 20'(i), 20'(cmd));
      check("cmd valid", 20'(i < 7), 20'(cmd_valid));
      check("cmd bank", 20'(i % 8), 20'(cmd_bank));
      repeat (2) send(DDRCI_CMD_NOP, 1'b1, 1'b0);
    end
  endtask
  // A precharge is sent with the clock enable high so that the bank closes first.
  task automatic t_pwr(input ddrci_cmd_t c, input ddrci_state_t s);
    send(c, 1'(c == DDRCI_CMD_PRE), 1'b1);
    repeat (3) send(DDRCI_CMD_NOP, 1'b0, 1'b1);
    check("state", 20'(s), 20'(pwr_state));
    if (s == DDRCI_ST_SREF) begin
      check("sref odt", 20'h0, odt_on);
      check("sref clk buf", 20'h0, 20'(clk_buf_en));
    end else begin
      check("pd odt buf", 20'h1, 20'(odt_buf_en));
    end
    repeat (5) send(DDRCI_CMD_NOP, 1'b1, 1'b0);
    check("wake", 20'(DDRCI_ST_ACTIVE), 20'(pwr_state));
  endtask
  task automatic t_odt;
    logic [19:0] exp [3] = '{20'hFFFFF, 20'h500FF, 20'h00000};
    for (int i = 0; i < 3; i++) begin
      send(DDRCI_CMD_NOP, 1'b1, 1'b1);
      emr_odt_enable = 1'(i < 2);
      width_x16 = 1'(i == 0);
      repeat (2) send(DDRCI_CMD_NOP, 1'b1, 1'b1);
      check("odt on", exp[i], odt_on);
      repeat (2) send(DDRCI_CMD_NOP, 1'b1, 1'b0);
      check("odt off", 20'h0, odt_on);
    end
    emr_odt_enable = 1'b1;
    width_x16 = 1'b1;
  endtask
  task automatic t_read;
    @(negedge mclk);
    rd_rise = 16'hA5A5;
    rd_fall = 16'h5A5A;
    rd_valid = 1'b1;
    for (int i = 0; i < 4 && dq_oe_n !== 1'b0; i++) @(posedge mclk) #2;
    check("dq oe", 20'h0, 20'(dq_oe_n));
    check("dq rise", 20'hA5A5, 20'(dq_out));
    @(negedge mclk) #2;
    check("dq fall", 20'h5A5A, 20'(dq_out));
    @(negedge mclk);
    rd_valid = 1'b0;
    repeat (3) @(negedge mclk);
    check("dq release", 20'h1, 20'(dq_oe_n));
  endtask
  // Reset in mid-run with a bank open and termination on; both must be cleared.
  task automatic t_reset;
    send(DDRCI_CMD_ACT, 1'b1, 1'b1);
    send(DDRCI_CMD_NOP, 1'b1, 1'b1);
    send(DDRCI_CMD_NOP, 1'b1, 1'b0);
    check("pre rst odt", 20'hFFFFF, odt_on);
    nrst = 1'b0;
    @(negedge mclk);
    check("rst state", 20'(DDRCI_ST_ACTIVE), 20'(pwr_state));
    check("rst cmd", 20'(DDRCI_CMD_DESEL), 20'(cmd));
    check("rst odt", 20'h0, odt_on);
    check("rst dq oe", 20'h1, 20'(dq_oe_n));
    @(negedge mclk);
    nrst = 1'b1;
    repeat (2) begin
      @(negedge mclk);
      check("rst exit state", 20'(DDRCI_ST_ACTIVE), 20'(pwr_state));
    end
    t_pwr(DDRCI_CMD_NOP, DDRCI_ST_PPD);
  endtask
  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    mismatches = 0;
    compares = 0;
    nrst = 1'b0;
    req_cmd = DDRCI_CMD_NOP;
    req_cke = 1'b1;
    req_odt = 1'b0;
    a10 = 1'b1;
    bank_addr = 3'h2;
    width_x16 = 1'b1;
    emr_odt_enable = 1'b1;
    rd_valid = 1'b0;
    rd_rise = 16'h0000;
    rd_fall = 16'h0000;
    repeat (8) @(negedge mclk);
    nrst = 1'b1;
    repeat (2) @(negedge mclk);
    t_cmds();
    t_pwr(DDRCI_CMD_NOP, DDRCI_ST_APD);
    // Single-bank precharge of the bank opened by the activate in t_cmds.
    a10 = 1'b0;
    bank_addr = 3'h3;
    t_pwr(DDRCI_CMD_PRE, DDRCI_ST_PPD);
    t_pwr(DDRCI_CMD_REF, DDRCI_ST_SREF);
    t_odt();
    t_read();
    t_reset();
    end_sim();
  end
  // The tests need about 110 cycles; this limit is many times that.
  initial begin
    #20000;
    mismatches++;
    end_sim();
  end
endmodule // ddrci_ctrl_tb
`default_nettype wire
